// File: logic/ppoc_pkg.sv
`default_nettype none
package ppoc_pkg;
  localparam int          PORT_COUNT      = 4;
  localparam int          CLK_FREQ_HZ     = 125_000_000;
  localparam int          SINGLE_LOW_MS   = 5;
  localparam int          DOUBLE_WIN_MS   = 20;
  localparam int          SINGLE_CYC      = SINGLE_LOW_MS * (CLK_FREQ_HZ / 1000);
  localparam int          DOUBLE_CYC      = DOUBLE_WIN_MS * (CLK_FREQ_HZ / 1000);
  localparam int          CNT_W           = 22;
  localparam int          FILT_LEN        = 4;
  localparam logic [21:0] CNT_ZERO        = 22'h000000;
  localparam logic [21:0] CNT_ONE         = 22'h000001;

  typedef enum logic {
    PPOC_MODE_GANGED,
    PPOC_MODE_COMBINED
  } ppoc_mode_e;

  typedef enum logic [1:0] {
    PPOC_SRC_HUB,
    PPOC_SRC_CPU
  } ppoc_src_e;

  typedef struct packed {
    logic o;
    logic oe_n;
    logic pu_en;
  } ppoc_pin_drive_s;
endpackage : ppoc_pkg
`default_nettype wire

// File: logic/ppoc_oc_detect.sv
`default_nettype none
module ppoc_oc_detect
  import ppoc_pkg::*;
#(
  parameter int SINGLE_CYCLES = SINGLE_CYC,
  parameter int WINDOW_CYCLES = DOUBLE_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic srst,
  // sense
  input  wire logic enable,
  input  wire logic sense_low,
  // result
  output logic      oc_pulse
);
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] low_cnt_next;
  logic [CNT_W-1:0] win_cnt_reg;
  logic [CNT_W-1:0] win_cnt_next;
  logic             prev_low_reg;
  logic             armed_reg;
  logic             armed_next;
  logic             oc_next;

  wire logic fall      = sense_low && !prev_low_reg;
  wire logic win_open  = armed_reg && (win_cnt_reg < WINDOW_CYCLES[CNT_W-1:0]);
  wire logic single_hit = sense_low && (low_cnt_reg == SINGLE_CYCLES[CNT_W-1:0] - CNT_ONE);
  wire logic double_hit = fall && win_open;

  assign low_cnt_next = !enable || !sense_low ? CNT_ZERO :
                        (single_hit ? low_cnt_reg : low_cnt_reg + CNT_ONE);
  assign armed_next   = enable && (fall ? !double_hit : (armed_reg && win_open));
  assign win_cnt_next = !enable || fall ? CNT_ZERO :
                        (armed_reg ? win_cnt_reg + CNT_ONE : CNT_ZERO);
  assign oc_next      = enable && (single_hit || double_hit);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      low_cnt_reg  <= CNT_ZERO;
      win_cnt_reg  <= CNT_ZERO;
      prev_low_reg <= 1'b0;
      armed_reg    <= 1'b0;
      oc_pulse     <= 1'b0;
    end else begin
      low_cnt_reg  <= low_cnt_next;
      win_cnt_reg  <= win_cnt_next;
      // ungated, so a port powered up into a stale low sees no false falling edge
      prev_low_reg <= sense_low;
      armed_reg    <= armed_next;
      oc_pulse     <= oc_next;
    end
  end

  chk_single_count: assert property (@(posedge core_clk) disable iff (srst)
    (enable && sense_low && low_cnt_reg == SINGLE_CYCLES[CNT_W-1:0] - CNT_ONE) |=> oc_pulse)
    else $error("long low did not flag over-current");
  chk_no_oc_idle: assert property (@(posedge core_clk) disable iff (srst)
    !$past(enable) |-> !oc_pulse)
    else $error("over-current flagged while port unpowered");
endmodule : ppoc_oc_detect
`default_nettype wire

// File: logic/ppoc_port_ctl.sv
`default_nettype none
// Functional notes
// - The block runs in either ganged or combined port control mode.
// - Ganged mode uses one shared pin for power and sensing of all ports.
// - Combined mode gives each port its own power and sense pin.
// - Power comes from either the hub logic or the embedded processor.
// - A powered-off port drives its pin low with the pull-up off.
// - A powered port releases the pin and enables the pull-up.
// - A powered port's pin is sampled continuously for over-current.
// - One continuous low of at least 5 ms is an over-current.
// - Two separate low groups within a 20 ms window are an over-current.
// - Short transient lows are filtered out before detection.
module ppoc_port_ctl
  import ppoc_pkg::*;
#(
  parameter int SINGLE_CYCLES = SINGLE_CYC,
  parameter int WINDOW_CYCLES = DOUBLE_CYC
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  // configuration
  input  wire ppoc_pkg::ppoc_mode_e  mode,
  input  wire ppoc_pkg::ppoc_src_e   ctl_src,
  // power requests
  input  wire logic [PORT_COUNT-1:0] hub_pwr_on,
  input  wire logic [PORT_COUNT-1:0] cpu_pwr_on,
  // status update
  input  wire logic [PORT_COUNT-1:0] oc_clear,
  output logic      [PORT_COUNT-1:0] oc_flag,
  output logic      [PORT_COUNT-1:0] port_powered,
  // per-port pins
  input  wire logic [PORT_COUNT-1:0] port_power_sense_pin_i,
  output logic      [PORT_COUNT-1:0] port_power_sense_pin_o,
  output logic      [PORT_COUNT-1:0] port_power_sense_pin_oe_n,
  output logic      [PORT_COUNT-1:0] port_pullup_en,
  // shared pin
  input  wire logic                  shared_power_sense_pin_i,
  output logic                       shared_power_sense_pin_o,
  output logic                       shared_power_sense_pin_oe_n,
  output logic                       shared_pullup_en
);
  logic [PORT_COUNT-1:0] pwr_reg;
  logic [PORT_COUNT-1:0] pin_s1_reg;
  logic [PORT_COUNT-1:0] pin_s2_reg;
  logic                  sh_s1_reg;
  logic                  sh_s2_reg;
  logic [PORT_COUNT-1:0] oc_reg;
  logic [PORT_COUNT-1:0] oc_hit;
  logic                  sh_hit;
  logic [FILT_LEN-1:0]   sh_filt_reg;
  logic                  sh_low_reg;
  ppoc_pin_drive_s       sh_drv;

  wire logic                  ganged   = (mode == PPOC_MODE_GANGED);
  wire logic [PORT_COUNT-1:0] pwr_req  = (ctl_src == PPOC_SRC_CPU) ? cpu_pwr_on : hub_pwr_on;
  wire logic                  gang_req = |pwr_req;
  wire logic                  gang_oc   = |oc_reg;
  wire logic                  gang_en   = ganged && pwr_reg[0];
  wire logic [PORT_COUNT-1:0] gang_next = {PORT_COUNT{gang_req && !gang_oc}};
  wire logic [PORT_COUNT-1:0] comb_next = pwr_req & ~oc_reg;
  wire logic [PORT_COUNT-1:0] pwr_next  = ganged ? gang_next : comb_next;

  // power drops at once on an over-current so a shorted load is not held on
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwr_reg <= '0;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // pins are asynchronous to core_clk
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      sh_s1_reg  <= 1'b1;
      sh_s2_reg  <= 1'b1;
    end else begin
      pin_s1_reg <= port_power_sense_pin_i;
      pin_s2_reg <= pin_s1_reg;
      sh_s1_reg  <= shared_power_sense_pin_i;
      sh_s2_reg  <= sh_s1_reg;
    end
  end

  // glitch filter: a low counts only after FILT_LEN agreeing samples; costs a few cycles of latency
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sh_filt_reg <= '1;
      sh_low_reg  <= 1'b0;
    end else begin
      sh_filt_reg <= {sh_filt_reg[FILT_LEN-2:0], sh_s2_reg};
      if (sh_filt_reg == '0) begin
        sh_low_reg <= 1'b1;
      end else if (sh_filt_reg == '1) begin
        sh_low_reg <= 1'b0;
      end
    end
  end

  ppoc_oc_detect #(
    .SINGLE_CYCLES(SINGLE_CYCLES),
    .WINDOW_CYCLES(WINDOW_CYCLES)
  ) u_gang_det (
    .core_clk (core_clk),
    .srst     (srst),
    .enable   (gang_en),
    .sense_low(sh_low_reg),
    .oc_pulse (sh_hit)
  );

  genvar g;
  generate
    for (g = 0; g < PORT_COUNT; g++) begin : g_port
      logic [FILT_LEN-1:0] filt_reg;
      logic                low_reg;
      logic                flag_reg;
      wire logic           det_en = !ganged && pwr_reg[g];
      always_ff @(posedge core_clk) begin
        if (srst) begin
          filt_reg <= '1;
          low_reg  <= 1'b0;
        end else begin
          filt_reg <= {filt_reg[FILT_LEN-2:0], pin_s2_reg[g]};
          if (filt_reg == '0) begin
            low_reg <= 1'b1;
          end else if (filt_reg == '1) begin
            low_reg <= 1'b0;
          end
        end
      end

      ppoc_oc_detect #(
        .SINGLE_CYCLES(SINGLE_CYCLES),
        .WINDOW_CYCLES(WINDOW_CYCLES)
      ) u_det (
        .core_clk (core_clk),
        .srst     (srst),
        .enable   (det_en),
        .sense_low(low_reg),
        .oc_pulse (oc_hit[g])
      );

      // set wins over clear
      always_ff @(posedge core_clk) begin
        if (srst) begin
          flag_reg <= 1'b0;
        end else if (oc_hit[g] || (ganged && sh_hit)) begin
          flag_reg <= 1'b1;
        end else if (oc_clear[g]) begin
          flag_reg <= 1'b0;
        end
      end
      assign oc_reg[g] = flag_reg;

      // off or ganged: drive 0, pull-up off; on in combined mode: release, pull-up on
      assign port_power_sense_pin_o[g]    = 1'b0;
      assign port_power_sense_pin_oe_n[g] = !ganged && pwr_reg[g];
      assign port_pullup_en[g]            = !ganged && pwr_reg[g];
    end
  endgenerate

  assign sh_drv.o    = 1'b0;
  assign sh_drv.oe_n = gang_en;
  assign sh_drv.pu_en = gang_en;
  assign shared_power_sense_pin_o    = sh_drv.o;
  assign shared_power_sense_pin_oe_n = sh_drv.oe_n;
  assign shared_pullup_en            = sh_drv.pu_en;
  assign oc_flag      = oc_reg;
  assign port_powered = pwr_reg;

  chk_off_drives_low: assert property (@(posedge core_clk) disable iff (srst)
    !port_powered[0] |-> (!port_power_sense_pin_oe_n[0] && !port_pullup_en[0]))
    else $error("unpowered port not driven low");
  chk_on_released: assert property (@(posedge core_clk) disable iff (srst)
    (!ganged && port_powered[1]) |-> (port_power_sense_pin_oe_n[1] && port_pullup_en[1]))
    else $error("powered port not released");
  chk_flag_sticky: assert property (@(posedge core_clk) disable iff (srst)
    (oc_flag[0] && !oc_clear[0]) |=> oc_flag[0])
    else $error("over-current flag lost without clear");
  chk_oc_cuts_power: assert property (@(posedge core_clk) disable iff (srst)
    (!ganged && $rose(oc_flag[1]) && $stable(mode)) |=> !port_powered[1])
    else $error("power stayed on after over-current");
  chk_src_select: assert property (@(posedge core_clk) disable iff (srst)
    (!ganged && ctl_src == PPOC_SRC_CPU && !cpu_pwr_on[2]) |=> !port_powered[2])
    else $error("processor power request ignored");
  chk_gang_shared: assert property (@(posedge core_clk) disable iff (srst)
    ganged |-> (port_power_sense_pin_oe_n == '0 && port_pullup_en == '0))
    else $error("per-port pin released in ganged mode");
  chk_glitch_filtered: assert property (@(posedge core_clk) disable iff (srst)
    (!ganged && $rose(oc_flag[1])) |-> $past(pin_s2_reg[1], FILT_LEN + 1) == 1'b0)
    else $error("over-current raised without sustained low");
  chk_gang_flags_all: assert property (@(posedge core_clk) disable iff (srst)
    (ganged && sh_hit) |=> (&oc_flag))
    else $error("ganged over-current not shown on all ports");


  chk_reset_pins_low: assert property (@(posedge core_clk)
    srst
    |=> (port_power_sense_pin_oe_n == '0 && port_pullup_en == '0 && !shared_power_sense_pin_oe_n))
    else $error("pins not driven low after reset");
  chk_reset_flags_clear: assert property (@(posedge core_clk)
    srst
    |=> (oc_flag == '0 && port_powered == '0))
    else $error("flags or power left over after reset");
  chk_pin_out_low: assert property (@(posedge core_clk) disable iff (srst)
    (port_power_sense_pin_o == '0)
    && !shared_power_sense_pin_o)
    else $error("pin output level not low");
  chk_pullup_tracks: assert property (@(posedge core_clk) disable iff (srst)
    (port_pullup_en == port_power_sense_pin_oe_n)
    && (shared_pullup_en == shared_power_sense_pin_oe_n))
    else $error("pull-up not tied to driver release");
  chk_off_port_driven: assert property (@(posedge core_clk) disable iff (srst)
    (port_power_sense_pin_oe_n & ~port_powered) == '0
    )
    else $error("unpowered port pin released");

  chk_combined_shared_low: assert property (@(posedge core_clk) disable iff (srst)
    !ganged
    |-> (!shared_power_sense_pin_oe_n && !shared_pullup_en))
    else $error("shared pin released in combined mode");
  chk_gang_equal_power: assert property (@(posedge core_clk) disable iff (srst)
    ganged
    |=> (port_powered == '0 || port_powered == '1))
    else $error("ganged ports powered unequally");
  chk_gang_release: assert property (@(posedge core_clk) disable iff (srst)
    (ganged && port_powered[0])
    |-> (shared_power_sense_pin_oe_n && shared_pullup_en))
    else $error("powered shared pin not released");
  chk_shared_needs_power: assert property (@(posedge core_clk) disable iff (srst)
    shared_power_sense_pin_oe_n
    |-> (ganged && port_powered[0]))
    else $error("shared pin released without power");
  chk_gang_oc_blocks: assert property (@(posedge core_clk) disable iff (srst)
    (ganged && oc_flag != '0)
    |=> (port_powered == '0))
    else $error("ganged power kept during over-current");

  chk_flag_blocks_power: assert property (@(posedge core_clk) disable iff (srst)
    (oc_flag != '0)
    |=> ((port_powered & $past(oc_flag)) == '0))
    else $error("flagged port still powered");
  chk_flag_needs_hit: assert property (@(posedge core_clk) disable iff (srst)
    $rose(oc_flag[3])
    |-> ($past(oc_hit[3]) || $past(ganged && sh_hit)))
    else $error("flag raised without detection");
  chk_clear_drops_flag: assert property (@(posedge core_clk) disable iff (srst)
    (oc_flag[3] && oc_clear[3] && !oc_hit[3] && !(ganged && sh_hit))
    |=> !oc_flag[3])
    else $error("status update did not clear flag");
  chk_single_power_cut: assert property (@(posedge core_clk) disable iff (srst)
    (!ganged && $rose(oc_flag[3]))
    |=> !port_powered[3])
    else $error("long low did not remove power");
  chk_hub_src_off: assert property (@(posedge core_clk) disable iff (srst)
    (!ganged && ctl_src == PPOC_SRC_HUB && !hub_pwr_on[2])
    |=> !port_powered[2])
    else $error("hub power request ignored");
  chk_cpu_src_on: assert property (@(posedge core_clk) disable iff (srst)
    (!ganged && ctl_src == PPOC_SRC_CPU && cpu_pwr_on[1] && !oc_flag[1])
    |=> port_powered[1])
    else $error("processor power request not applied");

  chk_shared_filter_low: assert property (@(posedge core_clk) disable iff (srst)
    $rose(sh_low_reg)
    |-> ($past(sh_s2_reg, 2) == 1'b0 && $past(sh_s2_reg, FILT_LEN + 1) == 1'b0))
    else $error("shared low accepted before filter");
  chk_port_filter_low: assert property (@(posedge core_clk) disable iff (srst)
    $rose(g_port[1].low_reg)
    |-> ($past(pin_s2_reg[1], 2) == 1'b0 && $past(pin_s2_reg[1], FILT_LEN + 1) == 1'b0))
    else $error("port low accepted before filter");
  chk_gang_det_quiet: assert property (@(posedge core_clk) disable iff (srst)
    (!ganged && !$past(ganged))
    |-> !sh_hit)
    else $error("shared detector active in combined mode");
  chk_port_det_quiet: assert property (@(posedge core_clk) disable iff (srst)
    (ganged && $past(ganged))
    |-> (oc_hit == '0))
    else $error("port detector active in ganged mode");
  chk_sync_port: assert property (@(posedge core_clk) disable iff (srst)
    pin_s2_reg == $past(pin_s1_reg)
    )
    else $error("port pin sync stage skipped");
  chk_sync_shared: assert property (@(posedge core_clk) disable iff (srst)
    sh_s2_reg == $past(sh_s1_reg)
    )
    else $error("shared pin sync stage skipped");

  cov_combined_oc: cover property (@(posedge core_clk) !ganged && $rose(oc_flag[0]));
  cov_double_oc:   cover property (@(posedge core_clk) !ganged && $rose(oc_flag[1]));
  cov_gang_power:  cover property (@(posedge core_clk) ganged && port_powered == '1);
  cov_ganged_oc:   cover property (@(posedge core_clk) ganged && sh_hit);
  cov_clear:       cover property (@(posedge core_clk) $fell(oc_flag[0]));
endmodule : ppoc_port_ctl
`default_nettype wire

// File: sim/ppoc_switch_model.sv
`default_nettype none
module ppoc_switch_model #(
  parameter int W = 1
) (
  // pin side of the block
  input  wire logic [W-1:0] pin_o,
  input  wire logic [W-1:0] pin_oe_n,
  input  wire logic [W-1:0] pullup_en,
  // fault command from the bench
  input  wire logic [W-1:0] fault,
  // level seen by the block
  output logic      [W-1:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // no power-good delay: fuse-style network answers at once
  always_comb begin
    for (int b = 0; b < W; b++) begin
      if (!pin_oe_n[b]) pin_i[b] = pin_o[b];
      else if (fault[b]) pin_i[b] = 1'b0; // open-drain pull low on fault
      else if (pullup_en[b]) pin_i[b] = 1'b1;
      else pin_i[b] = ~pin_o[b]; // floating: never echo the last driven level
    end
  end
endmodule : ppoc_switch_model
`default_nettype wire

// File: sim/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppoc_pkg::*;
  localparam int SC = 50;
  localparam int WC = 200;
  logic core_clk = 0, srst = 1;
  ppoc_mode_e mode = PPOC_MODE_COMBINED;
  ppoc_src_e ctl_src = PPOC_SRC_HUB;
  logic [3:0] hub_pwr_on = 0, cpu_pwr_on = 0, oc_clear = 0, fault = 0;
  logic [3:0] oc_flag, port_powered, pin_i, pin_o, pin_oe_n, pu_en;
  logic sh_i, sh_o, sh_oe_n, sh_pu, sh_fault = 0;
  int mismatches = 0, total_checks = 0;
  always #4 core_clk = ~core_clk;
  ppoc_port_ctl #(.SINGLE_CYCLES(SC), .WINDOW_CYCLES(WC)) i_dut (
    .core_clk(core_clk), .srst(srst), .mode(mode), .ctl_src(ctl_src),
    .hub_pwr_on(hub_pwr_on), .cpu_pwr_on(cpu_pwr_on), .oc_clear(oc_clear),
    .oc_flag(oc_flag), .port_powered(port_powered),
    .port_power_sense_pin_i(pin_i), .port_power_sense_pin_o(pin_o),
    .port_power_sense_pin_oe_n(pin_oe_n), .port_pullup_en(pu_en),
    .shared_power_sense_pin_i(sh_i), .shared_power_sense_pin_o(sh_o),
    .shared_power_sense_pin_oe_n(sh_oe_n), .shared_pullup_en(sh_pu));
  ppoc_switch_model #(.W(4)) i_sw (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .pullup_en(pu_en),
    .fault(fault), .pin_i(pin_i));
  ppoc_switch_model #(.W(1)) i_sw_sh (.pin_o(sh_o), .pin_oe_n(sh_oe_n), .pullup_en(sh_pu),
    .fault(sh_fault), .pin_i(sh_i));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wait_flag(input int b, input int n);
    for (int i = 0; i < n && oc_flag[b] !== 1'b1; i++) tick(1);
    check({3'b000, oc_flag[b]}, 4'h1);
  endtask : wait_flag
  task automatic t_reset();
    tick(3);
    check(pin_oe_n, 4'h0);
    check(pu_en, 4'h0);
    check(pin_o, 4'h0);
    check({3'b000, sh_o}, 4'h0);
    check(oc_flag | port_powered, 4'h0);
    srst = 0;
  endtask : t_reset
  task automatic t_power();
    hub_pwr_on = 4'h5;
    tick(2);
    check(port_powered, 4'h5);
    check(pin_oe_n & pu_en, 4'h5);
    check({2'b00, sh_oe_n, sh_pu}, 4'h0);
    ctl_src = PPOC_SRC_CPU;
    cpu_pwr_on = 4'hA;
    tick(2);
    check(port_powered, 4'hA);
    check(pin_oe_n | pu_en, 4'hA);
  endtask : t_power
  task automatic t_double();
    fault[1] = 1;
    tick(2);
    fault[1] = 0;
    tick(3 * WC);
    check(oc_flag, 4'h0);
    fault[1] = 1;
    tick(30);
    fault[1] = 0;
    tick(20);
    check(oc_flag, 4'h0);
    fault[1] = 1;
    tick(30);
    fault[1] = 0;
    wait_flag(1, 20);
    tick(10);
    check(oc_flag, 4'h2);
    check(port_powered, 4'h8);
  endtask : t_double
  task automatic t_clear();
    oc_clear = 4'hF;
    tick(2);
    oc_clear = 0;
    tick(2);
    check(oc_flag, 4'h0);
    check(port_powered, 4'hA);
  endtask : t_clear
  task automatic t_single();
    fault[3] = 1;
    tick(SC - 10);
    check(oc_flag, 4'h0);
    wait_flag(3, 30);
    tick(2);
    check(port_powered, 4'h2);
    check(pin_oe_n, 4'h2);
    fault[3] = 0;
    oc_clear = 4'hF;
    tick(2);
    oc_clear = 0;
  endtask : t_single
  task automatic t_ganged();
    mode = PPOC_MODE_GANGED;
    ctl_src = PPOC_SRC_HUB;
    hub_pwr_on = 4'h1;
    tick(3);
    check(port_powered, 4'hF);
    check({2'b00, sh_oe_n, sh_pu}, 4'h3);
    check(pin_oe_n | pu_en, 4'h0);
    sh_fault = 1;
    tick(SC + 20);
    check(oc_flag, 4'hF);
    check(port_powered, 4'h0);
    check({3'b000, sh_oe_n}, 4'h0);
  endtask : t_ganged
  task automatic summarize();
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
  initial begin
    t_reset();
    t_power();
    t_double();
    t_clear();
    t_single();
    t_ganged();
    summarize();
  end
endmodule : tb
`default_nettype wire
